// file: rtl/cbtv_params.svh
`ifndef CBTV_PARAMS_SVH
`define CBTV_PARAMS_SVH

// ==========================================================
// clock and timing
`define CBTV_CLK_NS        100
`define CBTV_T_CAENT_NS    250
`define CBTV_T_MRW_NS      100
`define CBTV_CAENT_CYC     ((`CBTV_T_CAENT_NS + `CBTV_CLK_NS - 1) / `CBTV_CLK_NS)
`define CBTV_MRW_CYC       ((`CBTV_T_MRW_NS + `CBTV_CLK_NS - 1) / `CBTV_CLK_NS)
`define CBTV_CNT_W         4

// ==========================================================
// mode register addresses
`define CBTV_MA_TERM_CFG   6'h0B
`define CBTV_MA_CA_REF     6'h0C
`define CBTV_MA_SP_CTRL    6'h0D
`define CBTV_MA_DQ_REF     6'h0E
`define CBTV_MA_TERM_EXTRA 6'h16

// ==========================================================
// command codes on ca[4:0] with cs high
`define CBTV_CMD_MRW1      5'h06
`define CBTV_CMD_MRW2      5'h16

// ==========================================================
// field positions
`define CBTV_SP_TRAIN_BIT  0
`define CBTV_SP_REFERENCE_HIGH_CURRENT_MODE_BIT   3
`define CBTV_SP_WR_BIT     6
`define CBTV_SP_OP_BIT     7
`define CBTV_REF_RANGE_BIT 6
`define CBTV_DQ_TERM_MSB   2
`define CBTV_CA_TERM_MSB   6
`define CBTV_CA_TERM_LSB   4

// ==========================================================
// reset values
`define CBTV_CA_REF_RST    8'h4D
`define CBTV_DQ_REF_RST    8'h4D
`define CBTV_TERM_CFG_RST  8'h00
`define CBTV_TERM_EXT_RST  8'h00
`define CBTV_SP_CTRL_RST   8'h00

// ==========================================================
// synchroniser width: ck, cke, cs, ca[5:0], dqs_t, dqs_c, dq[6:0]
`define CBTV_SYNC_W        18

`endif

// file: rtl/cbtv_pkg.sv
package cbtv_pkg;

	// ==========================================================
	// training sequence states
	typedef enum logic [4:0] {
		ST_IDLE    = 5'h01,
		ST_ARMED   = 5'h02,
		ST_TRAIN   = 5'h04,
		ST_POST    = 5'h08,
		ST_RECOVER = 5'h10
	} cbtv_state_t;

	// ==========================================================
	// mode register write decoder phases
	typedef enum logic [2:0] {
		CMD_FIRST = 3'h1,
		CMD_ADDR  = 3'h2,
		CMD_DATA  = 3'h4
	} cbtv_cmd_t;

	typedef logic [7:0] cbtv_mr_t;

endpackage : cbtv_pkg

// file: rtl/cbtv_sync.sv
`include "cbtv_params.svh"

module cbtv_sync (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// raw and synchronised levels
	input  wire logic [`CBTV_SYNC_W-1:0]  d,
	output logic      [`CBTV_SYNC_W-1:0]  q
);

	logic [`CBTV_SYNC_W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : cbtv_sync

// file: rtl/cbtv_top.sv
`include "cbtv_params.svh"

module cbtv_top (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// command link from the controller
	input  wire logic       ck_t,
	input  wire logic       cke,
	input  wire logic       cs,
	input  wire logic [5:0] ca,
	// low byte strobe and data inputs
	input  wire logic       dqs0_t,
	input  wire logic       dqs0_c,
	input  wire logic [6:0] dq_in,
	// feedback on lines 13..8, lines 15..14 floating
	output logic      [5:0] dq_fb_out,
	output logic            dq_fb_oe_n,
	output logic            dq_top_oe_n,
	// operating state
	output logic            training_active,
	output logic            active_setpoint,
	output logic            write_setpoint,
	output logic            normal_ready,
	output logic            vref_high_current,
	output logic      [5:0] dq_vref_level,
	output logic            dq_vref_range,
	output logic      [5:0] ca_vref_level,
	output logic            ca_vref_range,
	output logic            dq_term_on,
	output logic      [2:0] ca_term_code
);

	// ==========================================================
	// helpers
	function automatic logic is_addr(input logic [5:0] ma, input logic [5:0] target);
		is_addr = (ma == target);
	endfunction : is_addr

	// ==========================================================
	// pin synchronisation
	logic [`CBTV_SYNC_W-1:0] sync_q;
	logic                    ck_s;
	logic                    ck_q;
	logic                    cke_s;
	logic                    cs_s;
	logic [5:0]              ca_s;
	logic                    dqs_t_s;
	logic                    dqs_t_q;
	logic                    dqs_c_s;
	logic [6:0]              dq_s;
	cbtv_sync u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({ck_t, cke, cs, ca, dqs0_t, dqs0_c, dq_in}),
		.q       (sync_q)
	);
	assign {ck_s, cke_s, cs_s, ca_s, dqs_t_s, dqs_c_s, dq_s} = sync_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ck_q    <= 1'b0;
			dqs_t_q <= 1'b0;
		end else begin
			ck_q    <= ck_s;
			dqs_t_q <= dqs_t_s;
		end
	end
	wire ck_rise  = ck_s & ~ck_q;
	// differential pair: true rising while complement low
	wire dqs_rise = dqs_t_s & ~dqs_t_q & ~dqs_c_s;

	// ==========================================================
	// mode register write decoder
	// commands only decode while cke is high; training keeps it low
	cbtv_pkg::cbtv_cmd_t cmd_ph;
	cbtv_pkg::cbtv_cmd_t next_cmd_ph;
	logic                op7;
	logic                op6;
	logic [5:0]          mr_addr;
	logic                mr_wr;
	logic [7:0]          mr_data;
	wire cmd_slot  = ck_rise & cke_s;
	wire is_mrw1   = cs_s & (ca_s[4:0] == `CBTV_CMD_MRW1);
	wire is_mrw2   = cs_s & (ca_s[4:0] == `CBTV_CMD_MRW2);
	wire fire_wr   = cmd_slot & (cmd_ph == cbtv_pkg::CMD_DATA);
	always_comb begin
		next_cmd_ph = cmd_ph;
		if (cmd_slot) begin
			unique case (cmd_ph)
				cbtv_pkg::CMD_FIRST: begin
					if (is_mrw1) begin
						next_cmd_ph = cbtv_pkg::CMD_ADDR;
					end else if (is_mrw2) begin
						next_cmd_ph = cbtv_pkg::CMD_DATA;
					end
				end
				cbtv_pkg::CMD_ADDR: next_cmd_ph = cbtv_pkg::CMD_FIRST;
				cbtv_pkg::CMD_DATA: next_cmd_ph = cbtv_pkg::CMD_FIRST;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmd_ph  <= cbtv_pkg::CMD_FIRST;
			op7     <= 1'b0;
			op6     <= 1'b0;
			mr_addr <= 6'h00;
			mr_wr   <= 1'b0;
			mr_data <= 8'h00;
		end else begin
			cmd_ph <= next_cmd_ph;
			mr_wr  <= fire_wr;
			if (cmd_slot && cmd_ph == cbtv_pkg::CMD_FIRST && is_mrw1) begin
				op7 <= ca_s[5];
			end
			if (cmd_slot && cmd_ph == cbtv_pkg::CMD_FIRST && is_mrw2) begin
				op6 <= ca_s[5];
			end
			if (cmd_slot && cmd_ph == cbtv_pkg::CMD_ADDR) begin
				mr_addr <= ca_s;
			end
			if (fire_wr) begin
				mr_data <= {op7, op6, ca_s};
			end
		end
	end

	// ==========================================================
	// set-point control register, single copy
	cbtv_pkg::cbtv_mr_t sp_ctrl;
	wire sp_ctrl_wr = mr_wr & is_addr(mr_addr, `CBTV_MA_SP_CTRL);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sp_ctrl <= `CBTV_SP_CTRL_RST;
		end else if (sp_ctrl_wr) begin
			sp_ctrl <= mr_data;
		end
	end

	wire train_en = sp_ctrl[`CBTV_SP_TRAIN_BIT];
	wire active_parameter_setpoint   = sp_ctrl[`CBTV_SP_OP_BIT];
	wire write_target_setpoint   = sp_ctrl[`CBTV_SP_WR_BIT];

	// ==========================================================
	// per set-point operating registers
	cbtv_pkg::cbtv_mr_t ca_reference_setting [2];
	cbtv_pkg::cbtv_mr_t dq_reference_setting [2];
	cbtv_pkg::cbtv_mr_t termination_config_register [2];
	cbtv_pkg::cbtv_mr_t termination_extra_register [2];

	generate
		for (genvar sp = 0; sp < 2; sp++) begin : g_sp
			wire sel = mr_wr & (write_target_setpoint == 1'(sp));
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					ca_reference_setting[sp]        <= `CBTV_CA_REF_RST;
					dq_reference_setting[sp]        <= `CBTV_DQ_REF_RST;
					termination_config_register[sp] <= `CBTV_TERM_CFG_RST;
					termination_extra_register[sp]  <= `CBTV_TERM_EXT_RST;
				end else if (sel) begin
					if (is_addr(mr_addr, `CBTV_MA_CA_REF)) begin
						ca_reference_setting[sp] <= mr_data;
					end
					if (is_addr(mr_addr, `CBTV_MA_DQ_REF)) begin
						dq_reference_setting[sp] <= mr_data;
					end
					if (is_addr(mr_addr, `CBTV_MA_TERM_CFG)) begin
						termination_config_register[sp] <= mr_data;
					end
					if (is_addr(mr_addr, `CBTV_MA_TERM_EXTRA)) begin
						termination_extra_register[sp] <= mr_data;
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// training sequence
	cbtv_pkg::cbtv_state_t state;
	cbtv_pkg::cbtv_state_t next_state;
	logic [`CBTV_CNT_W-1:0] cnt;
	logic [6:0]             trained_code;
	logic                   trained_vld;
	logic                   act_sp;
	// entry is the same whether coming from idle or self refresh
	wire enter_train = (state == cbtv_pkg::ST_ARMED) & ~cke_s;
	wire exit_train  = (state == cbtv_pkg::ST_TRAIN) & cke_s;
	wire in_train    = (state == cbtv_pkg::ST_TRAIN);
	wire clear_seen  = sp_ctrl_wr & ~mr_data[`CBTV_SP_TRAIN_BIT];
	always_comb begin
		next_state = state;
		unique case (state)
			cbtv_pkg::ST_IDLE: begin
				if (train_en) begin
					next_state = cbtv_pkg::ST_ARMED;
				end
			end
			cbtv_pkg::ST_ARMED: begin
				if (!train_en) begin
					next_state = cbtv_pkg::ST_IDLE;
				end else if (!cke_s) begin
					next_state = cbtv_pkg::ST_TRAIN;
				end
			end
			cbtv_pkg::ST_TRAIN: begin
				if (cke_s) begin
					next_state = cbtv_pkg::ST_POST;
				end
			end
			cbtv_pkg::ST_POST: begin
				if (clear_seen) begin
					next_state = cbtv_pkg::ST_RECOVER;
				end
			end
			cbtv_pkg::ST_RECOVER: begin
				if (cnt == '0) begin
					next_state = cbtv_pkg::ST_IDLE;
				end
			end
			default: next_state = cbtv_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= cbtv_pkg::ST_IDLE;
			cnt   <= '0;
		end else begin
			state <= next_state;
			if (enter_train) begin
				cnt <= `CBTV_CNT_W'(`CBTV_CAENT_CYC);
			end else if (state == cbtv_pkg::ST_POST && clear_seen) begin
				cnt <= `CBTV_CNT_W'(`CBTV_MRW_CYC - 1);
			end else if (cnt != '0) begin
				cnt <= cnt - 1'b1;
			end
		end
	end
	// alternate set during training; revert on the very edge that ends it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			act_sp <= 1'b0;
		end else if (enter_train) begin
			act_sp <= ~active_parameter_setpoint;
		end else if (!in_train || exit_train) begin
			act_sp <= active_parameter_setpoint;
		end
	end
	// every strobe edge may overwrite the code; first edge may be lost
	wire take_code = in_train & dqs_rise & (cnt == '0);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trained_code <= 7'h00;
			trained_vld  <= 1'b0;
		end else if (exit_train) begin
			trained_vld  <= 1'b0;
		end else if (take_code) begin
			trained_code <= dq_s;
			trained_vld  <= 1'b1;
		end
	end

	// ==========================================================
	// command bus echo onto lines 13..8
	// registered at the captured edge, not delayed by any read latency
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dq_fb_out <= 6'h00;
		end else if (in_train && ck_rise && cs_s) begin
			dq_fb_out <= ca_s;
		end
	end

	assign dq_fb_oe_n  = ~in_train;
	assign dq_top_oe_n = 1'b1;

	// ==========================================================
	// operating outputs
	wire [7:0] ca_ref_sel = ca_reference_setting[act_sp];
	wire [7:0] dq_ref_sel = dq_reference_setting[act_sp];
	wire [7:0] term_sel   = termination_config_register[act_sp];
	wire [6:0] ca_code    = (in_train && trained_vld) ? trained_code : ca_ref_sel[6:0];
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dq_vref_level     <= 6'(`CBTV_DQ_REF_RST);
			dq_vref_range     <= 1'b0;
			ca_vref_level     <= 6'h00;
			ca_vref_range     <= 1'b0;
			dq_term_on        <= 1'b0;
			ca_term_code      <= 3'h0;
			vref_high_current <= 1'b0;
			normal_ready      <= 1'b0;
		end else begin
			dq_vref_level     <= dq_ref_sel[5:0];
			dq_vref_range     <= dq_ref_sel[`CBTV_REF_RANGE_BIT];
			ca_vref_level     <= ca_code[5:0];
			ca_vref_range     <= ca_code[`CBTV_REF_RANGE_BIT];
			// dq termination only matters while codes arrive on dq
			dq_term_on        <= in_train & (term_sel[`CBTV_DQ_TERM_MSB:0] != 3'h0);
			// no pad input exists: the pad level never reaches this logic
			ca_term_code      <= term_sel[`CBTV_CA_TERM_MSB:`CBTV_CA_TERM_LSB];
			vref_high_current <= sp_ctrl[`CBTV_SP_REFERENCE_HIGH_CURRENT_MODE_BIT];
			normal_ready      <= (state == cbtv_pkg::ST_IDLE);
		end
	end

	assign training_active    = in_train;
	assign active_setpoint    = act_sp;
	assign write_setpoint     = write_target_setpoint;

endmodule : cbtv_top

// file: bench/cbtv_properties.sv
module cbtv_properties (
	// clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// observed outputs
	input wire logic [5:0] dq_fb_out,
	input wire logic       dq_fb_oe_n,
	input wire logic       dq_top_oe_n,
	input wire logic       training_active,
	input wire logic       active_setpoint,
	input wire logic       normal_ready,
	input wire logic       dq_term_on
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// properties
	property p_fb_en; dq_fb_oe_n == !training_active; endproperty
	a_fb_en: assert property (p_fb_en) else $error("echo enable off training");
	property p_top_off; dq_top_oe_n == 1'b1; endproperty
	a_top_off: assert property (p_top_off) else $error("upper lines driven");
	property p_busy; training_active |-> !normal_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready during training");
	property p_enter; $rose(training_active) |-> active_setpoint != $past(active_setpoint); endproperty
	a_enter: assert property (p_enter) else $error("no set switch at entry");
	property p_exit; $fell(training_active) |-> active_setpoint != $past(active_setpoint); endproperty
	a_exit: assert property (p_exit) else $error("no set revert at exit");
	// register lags the state by one cycle
	property p_term; dq_term_on |-> training_active || $past(training_active); endproperty
	a_term: assert property (p_term) else $error("termination outside training");
	property p_echo; !training_active |=> $stable(dq_fb_out); endproperty
	a_echo: assert property (p_echo) else $error("echo moved outside training");
	// ready lags the state: low here means the cycle before was not idle
	property p_armed; $rose(training_active) |-> normal_ready == 1'b0; endproperty
	a_armed: assert property (p_armed) else $error("training without arming");
	property p_post; $fell(training_active) |-> !normal_ready [*2]; endproperty
	a_post: assert property (p_post) else $error("ready before exit write");

	// ==========================================================
	// coverage
	c_enter: cover property ($rose(training_active));
	c_exit: cover property ($fell(training_active));
	c_echo: cover property (training_active && $changed(dq_fb_out));
endmodule : cbtv_properties

bind cbtv_top cbtv_properties u_props (.clk, .sys_rst, .dq_fb_out, .dq_fb_oe_n, .dq_top_oe_n,
	.training_active, .active_setpoint, .normal_ready, .dq_term_on);

// file: bench/cbtv_ctrl_model.sv
module cbtv_ctrl_model (
	// clock
	input wire logic   clk,
	// command link
	output logic       ck_t,
	output logic       cke,
	output logic       cs,
	output logic [5:0] ca,
	// low byte strobe and data
	output logic       dqs0_t,
	output logic       dqs0_c,
	output logic [6:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ck_t = 1'b0;
		cke = 1'b1;
		cs = 1'b0;
		ca = 6'h00;
		dqs0_t = 1'b0;
		dqs0_c = 1'b1;
		dq_in = 7'h00;
	end

	// ==========================================================
	// one link clock period, 9 system clocks; ck stands still after
	task automatic cyc(input logic c, input logic [5:0] a);
		@(posedge clk);
		cs <= c;
		ca <= a;
		repeat (4) @(posedge clk);
		ck_t <= 1'b1;
		repeat (4) @(posedge clk);
		ck_t <= 1'b0;
	endtask : cyc

	// four rises per write, far wider than any step spacing
	task automatic mrw(input logic [7:0] a, input logic [7:0] op);
		cyc(1'b1, {op[7], 5'h06});
		cyc(1'b0, a[5:0]);
		cyc(1'b1, {op[6], 5'h16});
		cyc(1'b0, op[5:0]);
	endtask : mrw

	task automatic set_cke(input logic v);
		@(posedge clk);
		cke <= v;
		cs <= 1'b0;
		ca <= 6'h00;
	endtask : set_cke

	// first pulse may be lost, so always two
	task automatic strobe(input logic [6:0] code);
		@(posedge clk);
		dq_in <= code;
		repeat (2) begin
			repeat (3) @(posedge clk);
			dqs0_t <= 1'b1;
			dqs0_c <= 1'b0;
			repeat (3) @(posedge clk);
			dqs0_t <= 1'b0;
			dqs0_c <= 1'b1;
		end
		repeat (3) @(posedge clk);
		dq_in <= ~code;
	endtask : strobe
endmodule : cbtv_ctrl_model

// file: bench/tb_top.sv
`include "cbtv_params.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       ck_t, cke, cs, dqs0_t, dqs0_c, dq_fb_oe_n, dq_top_oe_n, training_active;
	logic       active_setpoint, write_setpoint, normal_ready, vref_high_current;
	logic       dq_vref_range, ca_vref_range, dq_term_on;
	logic [5:0] ca, dq_fb_out, ca_vref_level, dq_vref_level;
	logic [6:0] dq_in, code;
	logic [2:0] ca_term_code;
	logic [7:0] ca_m [2];
	logic [7:0] dq_m [2];
	logic [7:0] tc_m [2];
	logic [7:0] sp_m;
	logic [5:0] echo [3];
	int         err_total = 0;
	int         checks_done = 0;
	int         cycles = 0;

	cbtv_ctrl_model u_ctrl (.clk, .ck_t, .cke, .cs, .ca, .dqs0_t, .dqs0_c, .dq_in);
	cbtv_top u_dut (.clk, .sys_rst, .ck_t, .cke, .cs, .ca, .dqs0_t, .dqs0_c, .dq_in, .dq_fb_out,
		.dq_fb_oe_n, .dq_top_oe_n, .training_active, .active_setpoint, .write_setpoint,
		.normal_ready, .vref_high_current, .dq_vref_level, .dq_vref_range, .ca_vref_level,
		.ca_vref_range, .dq_term_on, .ca_term_code);

	always #50 clk = ~clk;

	// ==========================================================
	// checking
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// model: per-set registers, write target from set-point control
	task automatic wr(input logic [7:0] a, input logic [7:0] op);
		u_ctrl.mrw(a, op);
		repeat (8) @(posedge clk);
		case (a[5:0])
			`CBTV_MA_CA_REF: ca_m[sp_m[6]] = op;
			`CBTV_MA_DQ_REF: dq_m[sp_m[6]] = op;
			`CBTV_MA_TERM_CFG: tc_m[sp_m[6]] = op;
			`CBTV_MA_SP_CTRL: sp_m = op;
			default: ;
		endcase
	endtask : wr

	task automatic look(input logic tr, input logic [6:0] cav, input logic rdy);
		logic s;
		s = tr ^ sp_m[7];
		// sample away from the edge that launches the outputs
		@(negedge clk);
		chk({11'h0, dq_term_on, ca_term_code, vref_high_current, write_setpoint, active_setpoint,
			dq_vref_range, dq_vref_level, ca_vref_range, ca_vref_level},
			{11'h0, tr & (|tc_m[s][2:0]), tc_m[s][6:4], sp_m[3], sp_m[6], s, dq_m[s][6:0], cav});
		chk({28'h0, training_active, normal_ready, dq_fb_oe_n, dq_top_oe_n}, {28'h0, tr, rdy, ~tr, 1'b1});
	endtask : look

	// hang guard, several times the expected run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			err_total++;
			$display("mismatch t=%0t timeout", $time);
			test_done();
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		ca_m = '{`CBTV_CA_REF_RST, `CBTV_CA_REF_RST};
		dq_m = '{`CBTV_DQ_REF_RST, `CBTV_DQ_REF_RST};
		tc_m = '{`CBTV_TERM_CFG_RST, `CBTV_TERM_CFG_RST};
		sp_m = `CBTV_SP_CTRL_RST;
		void'($urandom(32'hBD63));
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		look(1'b0, ca_m[0][6:0], 1'b1);
		$display("test reset done");
		code = 7'($urandom);
		wr(`CBTV_MA_DQ_REF, {1'b0, code});
		wr(`CBTV_MA_SP_CTRL, 8'h48);
		wr(`CBTV_MA_CA_REF, {1'b0, 7'($urandom)});
		wr(`CBTV_MA_TERM_CFG, 8'h53);
		look(1'b0, ca_m[0][6:0], 1'b1);
		$display("test registers done");
		wr(`CBTV_MA_SP_CTRL, 8'h49);
		u_ctrl.set_cke(1'b0);
		u_ctrl.cyc(1'b0, 6'h00);
		look(1'b1, ca_m[1][6:0], 1'b0);
		for (int i = 0; i < 2; i++) begin
			code = 7'($urandom);
			u_ctrl.strobe(code);
			repeat (4) @(posedge clk);
			look(1'b1, code, 1'b0);
		end
		// command codes among the echoes must not decode with cke low
		echo = '{6'h06, 6'h16, 6'($urandom)};
		for (int i = 0; i < 3; i++) begin
			u_ctrl.cyc(1'b1, echo[i]);
			repeat (4) @(posedge clk);
			@(negedge clk);
			chk({26'h0, dq_fb_out}, {26'h0, echo[i]});
		end
		look(1'b1, code, 1'b0);
		$display("test training done");
		u_ctrl.cyc(1'b0, 6'h00);
		u_ctrl.set_cke(1'b1);
		repeat (6) @(posedge clk);
		look(1'b0, ca_m[0][6:0], 1'b0);
		wr(`CBTV_MA_SP_CTRL, 8'h48);
		look(1'b0, ca_m[0][6:0], 1'b1);
		wr(`CBTV_MA_CA_REF, {1'b0, code});
		wr(`CBTV_MA_SP_CTRL, 8'hC8);
		look(1'b0, code, 1'b1);
		$display("test exit done");
		test_done();
	end
endmodule : tb_top
